//--- logic/eeprom_bidir_pkg.sv
// Contract
// - scl falling edge enters transition mode
// - transition: watch control byte, count clock pulses
// - every scl fall clears pulse counter
// - 128 pulses, scl idle: back, restart 00h
// - control byte found: bidirectional until power-up
// - bidirectional: transmit-only clock only gates writes
// - bidirectional full array, transmit-only lower half
// - sda changes with scl high are conditions
// - sda fall, scl high is start
// - sda rise, scl high is stop
// - receiver pulls sda low on ninth clock
// - no acknowledge while programming runs
// - master nacks last read byte, sda released
// - control byte is 1010000 plus direction bit
// - ack only on address match, not busy
// - byte after control loads pointer, then data
// - stop after write data starts write cycle
// - transmit-only clock high throughout write transfer
// - page buffers eight bytes, commit after stop
// - only low three pointer bits increment
// - page overrun wraps within same page
// - write cycle ends within 10 ms
// - low transmit-only clock blocks all writes
package eeprom_bidir_pkg;

    // operating modes of the part
    typedef enum logic [1:0] {
        MODE_TX_ONLY,
        MODE_TRANSITION,
        MODE_BIDIR
    } mode_t;

    // two-wire slave receive phases
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_BITS,
        PH_ACK,
        PH_IGNORE
    } phase_t;

    localparam logic [6:0] DEV_ADDR = 7'h50;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [7:0] RECOVERY_PULSES = 8'h80;
    localparam logic [7:0] STREAM_START_ADDR = 8'h00;
    localparam logic [1:0] IDX_CONTROL = 2'h0;
    localparam logic [1:0] IDX_POINTER = 2'h1;
    localparam logic [1:0] IDX_DATA = 2'h2;

    // self-timed write: longest time rounds down to whole cycles
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned T_WR_MS = 10;
    localparam int unsigned T_WR_CYCLES = CLK_HZ / 1000 * T_WR_MS;
    localparam int unsigned TIMER_W = 20;

endpackage : eeprom_bidir_pkg

//--- logic/eeprom_pin_sync.sv
`timescale 1ns/1ps
// three-stage pin synchroniser; a new level is taken once stages two and three agree
module eeprom_pin_sync #(
    parameter logic INIT = 1'b1
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_pin,
    output logic o_level
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } sync_t;

    sync_t r_reg;
    sync_t r_next;

    // stage one feeds stage two only; the filter looks at two and three
    always_comb begin
        r_next = r_reg;
        r_next.s1 = i_pin;
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        if (r_reg.s2 == r_reg.s3) begin
            r_next.level = r_reg.s3;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            r_reg <= {INIT, INIT, INIT, INIT};
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_level = r_reg.level;

endmodule : eeprom_pin_sync

//--- logic/eeprom_array.sv
`timescale 1ns/1ps
// 256 x 8 cell array; contents survive reset like real nonvolatile cells
module eeprom_array (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_we,
    input wire logic [7:0] i_waddr,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] i_raddr,
    output logic [7:0] o_rdata
);

    logic [7:0] cells [256];
    logic [7:0] rdata_reg;

    // write port from the commit engine
    always_ff @(posedge i_mclk) begin
        if (i_we) begin
            cells[i_waddr] <= i_wdata;
        end
    end

    // registered read port
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= cells[i_raddr];
        end
    end

    assign o_rdata = rdata_reg;

endmodule : eeprom_array

//--- logic/eeprom_bidir_port.sv
`timescale 1ns/1ps
// bidirectional front end: mode transition, slave receive, page write, write timer
module eeprom_bidir_port
    import eeprom_bidir_pkg::*;
#(
    parameter int unsigned WR_CYCLES = T_WR_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe,
    input wire logic i_transmit_only_clock,
    input wire logic [7:0] i_rd_addr,
    output logic [7:0] o_rd_data,
    output logic o_bidir_mode,
    output logic o_transition_mode,
    output logic o_write_busy,
    output logic o_stream_restart,
    output logic [7:0] o_stream_addr
);

    typedef struct packed {
        // operating mode
        mode_t mode;

        // slave receive engine
        phase_t phase;
        logic [3:0] bit_cnt;
        logic [1:0] byte_idx;
        logic rd_cmd;
        logic [7:0] shift;

        // page buffer, pointer and write permission
        logic [7:0] ptr;
        logic [63:0] page;
        logic [7:0] page_mask;
        logic wr_ok;

        // self-timed write cycle
        logic busy;
        logic [TIMER_W-1:0] timer;
        logic [2:0] commit_idx;

        // pulse count for the fall back to transmit-only
        logic [7:0] rec_cnt;

        // edge history of the filtered pins
        logic scl_prev;
        logic sda_prev;
        logic txc_prev;

        // pin drive, stream handover and mode flags
        logic sda_out;
        logic sda_oe;
        logic restart;
        logic bidir;
        logic trans;
        logic [7:0] stream_addr;
    } state_t;

    state_t r_reg;
    state_t r_next;

    logic scl_lvl;
    logic sda_lvl;
    logic txc_lvl;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic txc_rise;
    logic mem_we;
    logic [7:0] mem_waddr;
    logic [7:0] mem_wdata;
    logic [7:0] mem_raddr;
    logic [7:0] rd_data;
    logic ack;
    logic [7:0] page_slot [8];

    // all three pins are asynchronous to the block clock
    // each stage resets to its pin's idle level, so leaving reset shows no edge
    eeprom_pin_sync #(.INIT(1'b1)) u_scl_sync (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_pin(i_scl),
        .o_level(scl_lvl)
    );

    eeprom_pin_sync #(.INIT(1'b1)) u_sda_sync (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_pin(i_sda),
        .o_level(sda_lvl)
    );

    eeprom_pin_sync #(.INIT(1'b0)) u_txc_sync (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_pin(i_transmit_only_clock),
        .o_level(txc_lvl)
    );

    // edges and bus conditions from the filtered levels
    assign scl_rise = ~r_reg.scl_prev & scl_lvl;
    assign scl_fall = r_reg.scl_prev & ~scl_lvl;
    assign txc_rise = ~r_reg.txc_prev & txc_lvl;
    // sda moving while scl stays high is never data
    assign start_cond = r_reg.scl_prev & scl_lvl & r_reg.sda_prev & ~sda_lvl;
    assign stop_cond = r_reg.scl_prev & scl_lvl & ~r_reg.sda_prev & sda_lvl;

    // transmit-only mode only sees the lower half of the array
    assign mem_raddr = {(r_reg.mode == MODE_BIDIR) & i_rd_addr[7], i_rd_addr[6:0]};

    eeprom_array u_array (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_we(mem_we),
        .i_waddr(mem_waddr),
        .i_wdata(mem_wdata),
        .i_raddr(mem_raddr),
        .o_rdata(rd_data)
    );

    // the page buffer seen as eight byte slots for the commit engine
    for (genvar g = 0; g < 8; g++) begin : g_slot
        assign page_slot[g] = r_reg.page[g*8 +: 8];
    end

    // next-state logic for the whole port
    always_comb begin
        r_next = r_reg;
        r_next.scl_prev = scl_lvl;
        r_next.sda_prev = sda_lvl;
        r_next.txc_prev = txc_lvl;
        // the restart strobe lasts one cycle: cleared here unless recovery sets it
        r_next.restart = 1'b0;
        r_next.sda_out = 1'b0;
        mem_we = 1'b0;
        mem_waddr = 8'h00;
        mem_wdata = 8'h00;
        ack = 1'b0;

        // mode transition and recovery
        unique case (r_reg.mode)
            MODE_TX_ONLY: begin
                // scl resting high keeps the part here; its first fall hands over
                if (scl_fall) begin
                    r_next.mode = MODE_TRANSITION;
                    r_next.rec_cnt = 8'h00;
                end
            end
            MODE_TRANSITION: begin
                if (scl_fall) begin
                    r_next.rec_cnt = 8'h00;
                end else if (txc_rise && scl_lvl) begin
                    // pulses only count while scl rests high
                    r_next.rec_cnt = r_reg.rec_cnt + 8'h01;
                    if (r_next.rec_cnt == RECOVERY_PULSES) begin
                        r_next.mode = MODE_TX_ONLY;
                        r_next.rec_cnt = 8'h00;
                        r_next.restart = 1'b1;
                        r_next.stream_addr = STREAM_START_ADDR;
                    end
                end
            end
            MODE_BIDIR: begin
                // no way back short of reset; pulse counting stops here
                r_next.rec_cnt = 8'h00;
            end
            default: begin
                // unused code: fall back to the power-up mode
                r_next.mode = MODE_TX_ONLY;
            end
        endcase

        // write permission drops the moment the clock pin goes low during a transfer
        // checked every cycle, so even a short low level past the filter spoils the page
        if (!r_reg.busy && !txc_lvl) begin
            r_next.wr_ok = 1'b0;
        end

        // slave receive engine
        if (start_cond) begin
            // any half-shifted byte is thrown away
            r_next.phase = PH_BITS;
            r_next.bit_cnt = 4'h0;
            r_next.byte_idx = IDX_CONTROL;
            r_next.sda_oe = 1'b0;
            if (!r_reg.busy) begin
                r_next.page_mask = 8'h00;
            end
        end else if (stop_cond) begin
            r_next.phase = PH_IDLE;
            r_next.bit_cnt = 4'h0;
            r_next.sda_oe = 1'b0;
            if (!r_reg.busy) begin
                // only acknowledged data bytes of a permitted write get programmed
                if (r_reg.mode == MODE_BIDIR && !r_reg.rd_cmd && r_reg.wr_ok
                        && r_reg.page_mask != 8'h00) begin
                    r_next.busy = 1'b1;
                    r_next.timer = '0;
                    r_next.commit_idx = 3'h0;
                end else begin
                    // no permission or nothing acknowledged: the page leaves no trace
                    r_next.page_mask = 8'h00;
                end
            end
        end else begin
            unique case (r_reg.phase)
                PH_IDLE: begin
                    // nothing to do until a start condition
                end
                PH_BITS: begin
                    if (scl_rise) begin
                        r_next.shift = {r_reg.shift[6:0], sda_lvl};
                        r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
                    end else if (scl_fall && r_reg.bit_cnt == BYTE_BITS) begin
                        unique case (r_reg.byte_idx)
                            IDX_CONTROL: begin
                                if (r_reg.shift[7:1] == DEV_ADDR
                                        && r_reg.mode != MODE_TX_ONLY) begin
                                    r_next.mode = MODE_BIDIR;
                                    r_next.rd_cmd = r_reg.shift[0];
                                    r_next.wr_ok = txc_lvl;
                                    ack = ~r_reg.busy;
                                end
                            end
                            IDX_POINTER: begin
                                if (!r_reg.rd_cmd) begin
                                    r_next.ptr = r_reg.shift;
                                    ack = ~r_reg.busy;
                                end
                            end
                            default: begin
                                if (!r_reg.rd_cmd && !r_reg.busy) begin
                                    // a ninth byte lands on the first slot again
                                    r_next.page[{r_reg.ptr[2:0], 3'h0} +: 8] = r_reg.shift;
                                    r_next.page_mask[r_reg.ptr[2:0]] = 1'b1;
                                    r_next.ptr[2:0] = r_reg.ptr[2:0] + 3'h1;
                                    ack = 1'b1;
                                end
                            end
                        endcase
                        if (ack) begin
                            r_next.phase = PH_ACK;
                            r_next.sda_oe = 1'b1;
                        end else begin
                            r_next.phase = PH_IGNORE;
                        end
                    end
                end
                PH_ACK: begin
                    // hold sda low across the ninth high phase, release on its fall
                    if (scl_fall) begin
                        r_next.sda_oe = 1'b0;
                        r_next.bit_cnt = 4'h0;
                        if (r_reg.rd_cmd && r_reg.byte_idx == IDX_CONTROL) begin
                            // reads are served elsewhere; leave sda free
                            r_next.phase = PH_IGNORE;
                        end else begin
                            r_next.phase = PH_BITS;
                            if (r_reg.byte_idx != IDX_DATA) begin
                                r_next.byte_idx = r_reg.byte_idx + 2'h1;
                            end
                        end
                    end
                end
                PH_IGNORE: begin
                    // wait for the next start or stop
                end
            endcase
        end

        // self-timed commit: pin level no longer matters here
        // one slot per cycle, empty slots skipped; the timer still runs its full length
        if (r_reg.busy) begin
            r_next.timer = r_reg.timer + 1'b1;
            if (r_reg.page_mask[r_reg.commit_idx]) begin
                mem_we = 1'b1;
                // upper five pointer bits pick the page, so overruns stay inside it
                mem_waddr = {r_reg.ptr[7:3], r_reg.commit_idx};
                mem_wdata = page_slot[r_reg.commit_idx];
                r_next.page_mask[r_reg.commit_idx] = 1'b0;
            end
            r_next.commit_idx = r_reg.commit_idx + 3'h1;
            // a shortened cycle must still cover all eight slots
            if (r_reg.timer == TIMER_W'(WR_CYCLES - 1)) begin
                r_next.busy = 1'b0;
            end
        end

        // mode flags leave through flops of their own, not through a decode of the mode
        r_next.bidir = (r_next.mode == MODE_BIDIR);
        r_next.trans = (r_next.mode == MODE_TRANSITION);
    end

    // single state register; power-up reset puts the part in transmit-only mode
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            // power-up: transmit-only, idle bus, empty page, no write running
            r_reg.mode <= MODE_TX_ONLY;
            r_reg.phase <= PH_IDLE;
            r_reg.bit_cnt <= 4'h0;
            r_reg.byte_idx <= IDX_CONTROL;
            r_reg.rd_cmd <= 1'b0;
            r_reg.shift <= 8'h00;
            r_reg.ptr <= 8'h00;
            r_reg.page <= '0;
            r_reg.page_mask <= 8'h00;
            r_reg.wr_ok <= 1'b0;
            r_reg.busy <= 1'b0;
            r_reg.timer <= '0;
            r_reg.commit_idx <= 3'h0;
            r_reg.rec_cnt <= 8'h00;
            // edge history starts at the idle pin levels so reset makes no false edge
            r_reg.scl_prev <= 1'b1;
            r_reg.sda_prev <= 1'b1;
            r_reg.txc_prev <= 1'b0;
            r_reg.sda_out <= 1'b0;
            r_reg.sda_oe <= 1'b0;
            r_reg.restart <= 1'b0;
            r_reg.bidir <= 1'b0;
            r_reg.trans <= 1'b0;
            r_reg.stream_addr <= STREAM_START_ADDR;
        end else begin
            r_reg <= r_next;
        end
    end

    // outputs straight from the state register; read data straight from the array's read register
    assign o_sda = r_reg.sda_out;
    assign o_sda_oe = r_reg.sda_oe;
    assign o_rd_data = rd_data;
    assign o_bidir_mode = r_reg.bidir;
    assign o_transition_mode = r_reg.trans;
    assign o_write_busy = r_reg.busy;
    assign o_stream_restart = r_reg.restart;
    assign o_stream_addr = r_reg.stream_addr;

endmodule : eeprom_bidir_port

//--- test/eeprom_bidir_port_chk.sv
`timescale 1ns/1ps
// port-level watch of the two-wire front end and its mode outputs
module eeprom_bidir_port_chk #(
    parameter int unsigned WR_CYCLES = 40
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_scl,
    input wire logic o_sda_oe,
    input wire logic o_bidir_mode,
    input wire logic o_transition_mode,
    input wire logic o_write_busy,
    input wire logic o_stream_restart,
    input wire logic [7:0] o_stream_addr
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    int unsigned busy_cyc;
    // age of the running write cycle, so its length can be bounded
    always_ff @(posedge i_mclk) begin
        busy_cyc <= (i_rst || !o_write_busy) ? 32'h0 : busy_cyc + 32'h1;
    end
    chk_mode_onehot: assert property (!(o_bidir_mode && o_transition_mode))
        else $error("both mode outputs high");
    chk_bidir_sticky: assert property (o_bidir_mode |=> o_bidir_mode)
        else $error("left bidirectional mode");
    chk_bidir_entry: assert property ($rose(o_bidir_mode) |-> $past(o_transition_mode))
        else $error("bidirectional mode not entered from transition");
    chk_trans_entry: assert property ($rose(o_transition_mode) |-> !i_scl)
        else $error("transition entered without scl low");
    chk_restart_state: assert property (
        o_stream_restart |-> !o_transition_mode && o_stream_addr == 8'h00 ##1 !o_stream_restart)
        else $error("bad restart pulse");
    chk_recover_pulse: assert property (
        $fell(o_transition_mode) && !o_bidir_mode |-> ##[0:2] o_stream_restart)
        else $error("recovery without restart pulse");
    chk_ack_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
        else $error("sda driver changed while scl high");
    chk_ack_hold: assert property ($rose(o_sda_oe) |-> o_sda_oe [*8])
        else $error("acknowledge released too soon");
    chk_busy_no_ack: assert property (o_write_busy |-> !o_sda_oe)
        else $error("acknowledge during write cycle");
    chk_busy_bound: assert property (o_write_busy |-> busy_cyc < WR_CYCLES)
        else $error("write cycle too long");
    chk_write_bidir: assert property ($rose(o_write_busy) |-> o_bidir_mode)
        else $error("write cycle outside bidirectional mode");
    cover property ($rose(o_bidir_mode));
    cover property (o_stream_restart);
    cover property ($fell(o_write_busy));
endmodule : eeprom_bidir_port_chk

//--- test/twi_master_model.sv
`timescale 1ns/1ps
// two-wire master; only ever pulls sda low, the bench pull-up gives the high level
module twi_master_model (
    input wire logic i_mclk,
    output logic o_scl,
    output logic o_sda_low,
    input wire logic i_sda
);
    localparam int STEP = 12;
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge i_mclk);
    endtask : wt
    // lone scl low pulse with sda idle
    task automatic blip;
        o_scl = 1'b0;
        wt(2 * STEP);
        o_scl = 1'b1;
        wt(2 * STEP);
    endtask : blip
    // sda falls with scl high; also serves as repeated start
    task automatic start;
        o_sda_low = 1'b0;
        wt(STEP);
        o_scl = 1'b1;
        wt(STEP);
        o_sda_low = 1'b1;
        wt(STEP);
        o_scl = 1'b0;
        wt(STEP);
    endtask : start
    // sda rises with scl high
    task automatic stop;
        o_sda_low = 1'b1;
        wt(STEP);
        o_scl = 1'b1;
        wt(STEP);
        o_sda_low = 1'b0;
        wt(STEP);
    endtask : stop
    // msb first, sda moved only while scl low; ninth clock given only when all eight bits are sent
    task automatic send_bits(input logic [7:0] val, input int n, output logic ack);
        for (int i = 7; i > 7 - n; i--) begin
            o_sda_low = !val[i];
            wt(STEP);
            o_scl = 1'b1;
            wt(2 * STEP);
            o_scl = 1'b0;
            wt(STEP);
        end
        ack = 1'b1;
        if (n == 8) begin
            o_sda_low = 1'b0;
            wt(STEP);
            o_scl = 1'b1;
            wt(STEP);
            ack = i_sda;
            wt(STEP);
            o_scl = 1'b0;
            wt(STEP);
        end
    endtask : send_bits
endmodule : twi_master_model

//--- test/dual_mode_eeprom_bidir_port_tb.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        err_count++; \
        $display("FAIL t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
end
module dual_mode_eeprom_bidir_port_tb;
    import eeprom_bidir_pkg::*;
    localparam int unsigned WR = 2000;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic transmit_only_clock = 1'b0;
    logic [7:0] rd_addr = 8'h00;
    logic scl, sda_low, oe, sda_o, bidir, trans, busy, restart, ack;
    logic [7:0] rd_data, saddr;
    int err_count = 0;
    int samples_checked = 0;
    int restart_cnt = 0;
    // open-drain wire with pull-up
    wire logic sda_line = ~(sda_low | (oe & ~sda_o));
    always #5 mclk = ~mclk;
    always @(posedge mclk) if (restart === 1'b1) restart_cnt++;
    eeprom_bidir_port #(.WR_CYCLES(WR)) i_dut (
        .i_mclk(mclk), .i_rst(rst), .i_scl(scl), .i_sda(sda_line), .o_sda(sda_o),
        .o_sda_oe(oe), .i_transmit_only_clock(transmit_only_clock), .i_rd_addr(rd_addr),
        .o_rd_data(rd_data), .o_bidir_mode(bidir), .o_transition_mode(trans),
        .o_write_busy(busy), .o_stream_restart(restart), .o_stream_addr(saddr));
    twi_master_model i_master (.i_mclk(mclk), .o_scl(scl), .o_sda_low(sda_low),
        .i_sda(sda_line));
    task automatic end_sim;
        if (err_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc
    task automatic vpulses(input int n);
        repeat (n) begin
            transmit_only_clock = 1'b1;
            cyc(6);
            transmit_only_clock = 1'b0;
            cyc(6);
        end
    endtask : vpulses
    // bounded wait; a timeout is a mismatch and closes the run
    task automatic wait_busy(input logic exp);
        int n;
        n = 0;
        while (busy !== exp && n < 3000) begin
            cyc(1);
            n++;
        end
        `CHK(busy, exp);
        if (busy !== exp) end_sim(); // limit used up, already counted as a mismatch
    endtask : wait_busy
    task automatic peek(input logic [7:0] addr, input logic [7:0] exp);
        rd_addr = addr;
        cyc(3);
        `CHK(rd_data, exp);
    endtask : peek
    task automatic xfer(input logic [7:0] ptr, input logic [7:0] d0, input int n);
        i_master.start();
        i_master.send_bits({DEV_ADDR, 1'b0}, 8, ack);
        `CHK(ack, 1'b0);
        i_master.send_bits(ptr, 8, ack);
        `CHK(ack, 1'b0);
        for (int i = 0; i < n; i++) begin
            i_master.send_bits(d0 + 8'(i), 8, ack);
            `CHK(ack, 1'b0);
        end
        i_master.stop();
    endtask : xfer
    task automatic t_recover;
        `CHK({bidir, trans, busy, oe, saddr}, 12'h000);
        i_master.blip();
        `CHK(trans, 1'b1);
        vpulses(100);
        i_master.blip();
        vpulses(127);
        `CHK({trans, 1'(restart_cnt == 0)}, 2'b11);
        vpulses(1);
        cyc(10);
        `CHK({trans, bidir, saddr}, {2'b00, STREAM_START_ADDR});
        `CHK(restart_cnt, 1);
    endtask : t_recover
    task automatic t_enter;
        i_master.blip();
        i_master.start();
        i_master.send_bits(8'hA2, 8, ack);
        `CHK(ack, 1'b1);
        i_master.stop();
        `CHK({trans, bidir}, 2'b10);
        transmit_only_clock = 1'b1;
        xfer(8'h85, 8'hA5, 1);
        `CHK(bidir, 1'b1);
        wait_busy(1'b1);
        transmit_only_clock = 1'b0; // a falling level must not stop programming
        i_master.start();
        i_master.send_bits({DEV_ADDR, 1'b0}, 8, ack);
        `CHK(ack, 1'b1);
        i_master.stop();
        wait_busy(1'b0);
        peek(8'h85, 8'hA5);
    endtask : t_enter
    task automatic t_page;
        vpulses(130);
        `CHK(bidir, 1'b1);
        transmit_only_clock = 1'b1;
        xfer(8'h1E, 8'hD0, 10);
        wait_busy(1'b1);
        wait_busy(1'b0);
        for (int s = 0; s < 8; s++) begin
            peek(8'h18 + 8'(s), 8'hD0 + 8'((s + 2) % 8 + (s >= 6 ? 8 : 0)));
        end
    endtask : t_page
    task automatic t_protect;
        xfer(8'h40, 8'h11, 1);
        wait_busy(1'b1);
        wait_busy(1'b0);
        transmit_only_clock = 1'b0;
        xfer(8'h40, 8'h22, 1);
        cyc(20);
        `CHK(busy, 1'b0);
        transmit_only_clock = 1'b1;
        i_master.start();
        i_master.send_bits({DEV_ADDR, 1'b0}, 8, ack);
        i_master.send_bits(8'h40, 8, ack);
        i_master.send_bits(8'h33, 4, ack);
        i_master.stop();
        cyc(20);
        `CHK(busy, 1'b0);
        peek(8'h40, 8'h11);
    endtask : t_protect
    // read command: acknowledged, then sda left free through the master's byte
    task automatic t_read;
        i_master.start();
        i_master.send_bits({DEV_ADDR, 1'b1}, 8, ack);
        `CHK(ack, 1'b0);
        i_master.send_bits(8'hFF, 8, ack);
        `CHK(ack, 1'b1);
        i_master.stop();
        cyc(20);
        `CHK({busy, oe}, 2'b00);
    endtask : t_read
    // power cycle: contents stay, only the lower half is visible again
    task automatic t_half;
        rst = 1'b1;
        cyc(6);
        rst = 1'b0;
        cyc(2);
        `CHK({bidir, trans, busy}, 3'b000);
        peek(8'h98, 8'hD2);
    endtask : t_half
    initial begin
        cyc(6);
        rst = 1'b0;
        cyc(2);
        t_recover();
        t_enter();
        t_page();
        t_protect();
        t_read();
        t_half();
        end_sim();
    end
endmodule : dual_mode_eeprom_bidir_port_tb
bind eeprom_bidir_port eeprom_bidir_port_chk #(.WR_CYCLES(WR_CYCLES)) i_chk (
    .i_mclk, .i_rst, .i_scl, .o_sda_oe, .o_bidir_mode, .o_transition_mode,
    .o_write_busy, .o_stream_restart, .o_stream_addr);
